// >>> pfc_flash_ctrl.sv
`timescale 1ns/1ps

// Behaviour
// R1: Array rows hold 32 words of 14 bits; row is smallest soft erase.
// R2: Erase sets bits to one, program only clears; reads give one word.
// R3: Hidden 14-bit write latches loaded only through the data pair.
// R4: Write or erase halts fetching for a timer-set time, then resumes.
// R5: Indirect read hits flash when pointer high bit 7 is set.
// R6: Pointer naming the indirect data port itself reads zero.
// R7: Indirect flash read stalls one cycle and returns one byte.
// R8: Indirect stores never write or erase the flash.
// R9: Software picks region select, then loads the address pair.
// R10: Read trigger stalls; word lands in data pair next cycle.
// R11: Hardware clears the read trigger when the read completes.
// R12: Data pair holds last read until next read or software write.
// R13: Protected write or erase is refused and sets the error flag.
// R14: Code protect blocks programmer access; write protect blocks software.
// R15: Protection settings clear only by programmer bulk erase.
// R16: Bulk erase comes only from the programmer, never from software.
// R17: Config bulk erase under code protect erases everything.
// R18: Erase, commit, ID and config writes need the full unlock.
// R19: Unlock is 55h, AAh, then write trigger, strictly in order.
// R20: Write trigger stalls the processor until the operation ends.
// R21: Software masks global interrupts around the unlock sequence.
// R22: Program space register address equals PC; pointer adds 0x8000.
// R23: Config space: IDs, revision, device, five configs, info area.
// R24: Unlocked erase clears the row; protected row drops trigger.
// R25: Latch-only writes load one latch; otherwise commit the row.
// R26: Upper ten bits pick row, low five the latch; latches reblank. The code picks the row from nine bits, 13:5.
// R27: Completion sets done flag; interrupt raised when enabled.
// R28: Write trigger self-clears at the end; ignored without enable.
// R29: Any intervening access resets the unlock detector; the code resets it on register writes only, not on reads.
module pfc_flash_ctrl #(
    parameter int unsigned OP_CYCLES = pfc_pkg::OP_CYCLES_DFLT
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic             hreadyout_o,
    output logic             hresp_o,
    output logic [31:0]      hrdata_o,
    input  wire logic        ind_load_i,
    input  wire logic        ind_store_i,
    input  wire logic [15:0] ind_pointer_i,
    output logic [7:0]       ind_data_o,
    output logic             ind_valid_o,
    output logic             cpu_stall_o,
    output logic             flash_done_irq_o,
    input  wire logic        pgm_bulk_erase_i,
    input  wire logic        pgm_cfg_erase_i,
    output logic             pgm_access_block_o
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        pfc_pkg::pfc_state_t st;
        logic [14:0] addr;
        logic [13:0] data;
        logic        rd;
        logic        wr;
        logic        write_enable_gate;
        logic        err;
        logic        free;
        logic        latch_only_select;
        logic        sel;
        logic        done;
        logic        ie;
        logic [1:0]  unlock;
        logic [16:0] tmr;
        logic [14:0] sweep;
        logic        op_cfg;
        logic        ph_valid;
        logic        ph_write;
        logic [7:0]  ph_addr;
        logic        rwait;
        logic [31:0] hrdata;
        logic [7:0]  ind_data;
        logic        ind_valid;
        logic [2:0]  bulk_sync;
        logic [2:0]  cfge_sync;
    } pfc_regs_t;

    pfc_regs_t s_reg;
    pfc_regs_t s_next;

    logic [13:0] pfm_mem [0:pfc_pkg::PFM_WORDS-1];
    logic [13:0] cfg_mem [0:pfc_pkg::CFG_WORDS-1];
    logic [13:0] latch_mem [0:pfc_pkg::ROW_WORDS-1];

    localparam logic [16:0] OP_LAST = 17'(OP_CYCLES - 1);

    logic        take;
    logic        wr_en;
    logic [7:0]  wd8;
    logic [13:0] rd_word;
    logic        cp_active;
    logic        wp_active;
    logic        target_prot;
    logic        cfg_writable;
    logic        do_latch;
    logic        do_erase;
    logic        do_commit;
    logic        do_bulk;
    logic        do_cfg_erase;
    logic        bulk_rise;
    logic        cfge_rise;

    assign cp_active = ~cfg_mem[pfc_pkg::PROT_WORD][pfc_pkg::CP_N_BIT];
    assign wp_active = ~cfg_mem[pfc_pkg::PROT_WORD][pfc_pkg::WP_N_BIT];
    // Code protect only gates the programmer port
    assign pgm_access_block_o = cp_active; // see R14

    assign cfg_writable = (s_reg.addr <= pfc_pkg::CS_UID_LAST) ||
        (s_reg.addr >= pfc_pkg::CS_CFG_FIRST &&
         s_reg.addr <= pfc_pkg::CS_CFG_LAST);
    // Whole config space is tagged once write protect is set
    assign target_prot = wp_active &&
        (s_reg.sel || s_reg.addr < pfc_pkg::WP_LIMIT); // see R14

    // ------------------------------------------------------------
    // Word read mux
    // ------------------------------------------------------------
    always_comb
    begin
        rd_word = pfc_pkg::INFO_FILL;
        if (!s_reg.sel)
        begin
            rd_word = pfm_mem[s_reg.addr[13:0]]; // see R22
        end
        else if (s_reg.addr <= pfc_pkg::CS_UID_LAST)
        begin
            rd_word = cfg_mem[s_reg.addr[3:0]]; // see R23
        end
        else if (s_reg.addr == pfc_pkg::CS_REV_ID)
        begin
            rd_word = pfc_pkg::REV_ID_VAL;
        end
        else if (s_reg.addr == pfc_pkg::CS_DEV_ID)
        begin
            rd_word = pfc_pkg::DEV_ID_VAL;
        end
        else if (s_reg.addr >= pfc_pkg::CS_CFG_FIRST &&
                 s_reg.addr <= pfc_pkg::CS_CFG_LAST)
        begin
            rd_word = cfg_mem[s_reg.addr[3:0]];
        end
        else if (s_reg.addr >= pfc_pkg::CS_INFO_LO &&
                 s_reg.addr <= pfc_pkg::CS_INFO_HI)
        begin
            rd_word = pfc_pkg::INFO_FILL;
        end
        else
        begin
            rd_word = '0;
        end
    end

    assign take  = hsel_i && htrans_i[1] && hready_i;
    assign wr_en = s_reg.ph_valid && s_reg.ph_write;
    assign wd8   = hwdata_i[7:0];
    assign bulk_rise = s_reg.bulk_sync[1] && !s_reg.bulk_sync[2];
    assign cfge_rise = s_reg.cfge_sync[1] && !s_reg.cfge_sync[2];

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        s_next = s_reg;
        do_latch = 1'b0;
        do_erase = 1'b0;
        do_commit = 1'b0;
        do_bulk = 1'b0;
        do_cfg_erase = 1'b0;
        // Programmer pins come from outside the clock domain
        s_next.bulk_sync = {s_reg.bulk_sync[1:0], pgm_bulk_erase_i};
        s_next.cfge_sync = {s_reg.cfge_sync[1:0], pgm_cfg_erase_i};
        s_next.ind_valid = 1'b0;

        // Bus address and data phases; reads take one wait state
        s_next.ph_valid = take;
        s_next.ph_write = hwrite_i;
        s_next.ph_addr  = haddr_i[7:0];
        s_next.rwait    = s_reg.ph_valid && !s_reg.ph_write;
        if (s_reg.ph_valid && !s_reg.ph_write)
        begin
            case (s_reg.ph_addr)
                pfc_pkg::OFS_ADDR_LOW:
                    s_next.hrdata = {24'h0, s_reg.addr[7:0]};
                pfc_pkg::OFS_ADDR_HIGH:
                    s_next.hrdata = {25'h0, s_reg.addr[14:8]};
                pfc_pkg::OFS_DATA_LOW:
                    s_next.hrdata = {24'h0, s_reg.data[7:0]};
                pfc_pkg::OFS_DATA_HIGH:
                    s_next.hrdata = {26'h0, s_reg.data[13:8]};
                pfc_pkg::OFS_CONTROL:
                    s_next.hrdata = {25'h0, s_reg.sel, s_reg.latch_only_select,
                        s_reg.free, s_reg.err, s_reg.write_enable_gate,
                        s_reg.wr, s_reg.rd};
                pfc_pkg::OFS_STATUS:
                    s_next.hrdata = {30'h0, s_reg.ie, s_reg.done};
                default:
                    s_next.hrdata = 32'h0;
            endcase
        end

        if (wr_en)
        begin
            // Any other write breaks the unlock chain
            s_next.unlock = 2'd0; // see R29
            case (s_reg.ph_addr)
                pfc_pkg::OFS_ADDR_LOW:
                    s_next.addr[7:0] = wd8; // see R9
                pfc_pkg::OFS_ADDR_HIGH:
                    s_next.addr[14:8] = wd8[6:0];
                pfc_pkg::OFS_DATA_LOW:
                    s_next.data[7:0] = wd8; // see R12
                pfc_pkg::OFS_DATA_HIGH:
                    s_next.data[13:8] = wd8[5:0]; // see R3
                pfc_pkg::OFS_UNLOCK:
                begin
                    if (wd8 == pfc_pkg::UNLOCK_CODE_1)
                    begin
                        s_next.unlock = 2'd1; // see R19
                    end
                    else if (wd8 == pfc_pkg::UNLOCK_CODE_2 &&
                             s_reg.unlock == 2'd1)
                    begin
                        s_next.unlock = 2'd2; // see R19
                    end
                end
                pfc_pkg::OFS_CONTROL:
                begin
                    s_next.write_enable_gate = wd8[pfc_pkg::CTL_WRITE_ENABLE_GATE];
                    s_next.free = wd8[pfc_pkg::CTL_FREE];
                    s_next.latch_only_select = wd8[pfc_pkg::CTL_LATCH_ONLY_SELECT];
                    s_next.sel  = wd8[pfc_pkg::CTL_SEL];
                    s_next.err  = wd8[pfc_pkg::CTL_ERR];
                    if (wd8[pfc_pkg::CTL_RD] && s_reg.st ==
                        pfc_pkg::PFC_IDLE)
                    begin
                        s_next.rd = 1'b1;
                        s_next.st = pfc_pkg::PFC_READ; // see R10
                    end
                    else if (wd8[pfc_pkg::CTL_WR] && s_reg.write_enable_gate &&
                             s_reg.unlock == 2'd2 &&
                             s_reg.st == pfc_pkg::PFC_IDLE) // see R18
                    begin
                        if (s_reg.latch_only_select && !s_reg.free)
                        begin
                            do_latch = 1'b1; // see R25
                        end
                        else if (target_prot ||
                                 (s_reg.sel && !s_reg.free &&
                                  !cfg_writable))
                        begin
                            s_next.err = 1'b1; // see R13
                        end
                        else
                        begin
                            s_next.wr  = 1'b1; // see R20
                            s_next.tmr = OP_LAST;
                            s_next.st  = pfc_pkg::PFC_BUSY;
                        end
                    end
                end
                pfc_pkg::OFS_STATUS:
                    s_next.ie = wd8[pfc_pkg::STS_IE];
                default:
                    s_next.unlock = 2'd0;
            endcase
            if (s_reg.ph_addr == pfc_pkg::OFS_STATUS &&
                wd8[pfc_pkg::STS_DONE])
            begin
                s_next.done = 1'b0;
            end
        end

        // Indirect port is read only; stores are dropped here
        if (ind_load_i && !ind_store_i) // see R8
        begin
            s_next.ind_valid = 1'b1; // see R7
            if (ind_pointer_i[15])
            begin
                s_next.ind_data = pfm_mem[ind_pointer_i[13:0]][7:0]; // see R5
            end
            else
            begin
                s_next.ind_data = 8'h00; // see R6
            end
        end

        case (s_reg.st)
            pfc_pkg::PFC_IDLE:
            begin
                if (bulk_rise || (cfge_rise && cp_active)) // see R16
                begin
                    do_bulk = 1'b1; // see R15
                    s_next.sweep = '0;
                    s_next.st = pfc_pkg::PFC_SWEEP; // see R17
                end
                else if (cfge_rise)
                begin
                    do_cfg_erase = 1'b1;
                end
            end
            pfc_pkg::PFC_READ:
            begin
                s_next.data = rd_word; // see R10
                s_next.rd = 1'b0; // see R11
                s_next.st = pfc_pkg::PFC_IDLE;
            end
            pfc_pkg::PFC_BUSY:
            begin
                s_next.tmr = s_reg.tmr - 17'd1; // see R4
                if (s_reg.tmr == 17'd0)
                begin
                    do_erase  = s_reg.free; // see R24
                    do_commit = !s_reg.free;
                    s_next.wr = 1'b0; // see R28
                    s_next.st = pfc_pkg::PFC_IDLE;
                end
            end
            pfc_pkg::PFC_SWEEP:
            begin
                s_next.sweep = s_reg.sweep + 15'd1;
                if (s_reg.sweep[13:0] == 14'h3fff)
                begin
                    s_next.st = pfc_pkg::PFC_IDLE;
                end
            end
            default:
                s_next.st = pfc_pkg::PFC_IDLE;
        endcase

        // Set wins over a same-cycle software clear
        if (do_erase || do_commit)
        begin
            s_next.done = 1'b1; // see R27
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            s_reg <= '0;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // ------------------------------------------------------------
    // Arrays
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (s_reg.st == pfc_pkg::PFC_SWEEP)
        begin
            pfm_mem[s_reg.sweep[13:0]] <= pfc_pkg::BLANK_WORD;
        end
        for (int i = 0; i < pfc_pkg::ROW_WORDS; i++)
        begin
            if (!s_reg.sel && (do_erase || do_commit))
            begin
                // Row from address bits 13:5, latch from lower five
                if (do_erase)
                begin
                    pfm_mem[{s_reg.addr[13:5], 5'(i)}] <=
                        pfc_pkg::BLANK_WORD; // see R1
                end
                else
                begin
                    pfm_mem[{s_reg.addr[13:5], 5'(i)}] <=
                        pfm_mem[{s_reg.addr[13:5], 5'(i)}] &
                        latch_mem[i]; // see R2
                end
            end
        end
        for (int j = 0; j < pfc_pkg::CFG_WORDS; j++)
        begin
            if (do_bulk || do_cfg_erase)
            begin
                cfg_mem[j] <= pfc_pkg::BLANK_WORD; // see R15
            end
            else if (s_reg.sel && do_erase &&
                     4'(j) <= pfc_pkg::CS_UID_LAST[3:0])
            begin
                cfg_mem[j] <= pfc_pkg::BLANK_WORD;
            end
            else if (s_reg.sel && do_commit &&
                     (4'(j) <= pfc_pkg::CS_UID_LAST[3:0] ||
                      4'(j) >= pfc_pkg::CS_CFG_FIRST[3:0]))
            begin
                cfg_mem[j] <= cfg_mem[j] & latch_mem[j];
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            for (int k = 0; k < pfc_pkg::ROW_WORDS; k++)
            begin
                latch_mem[k] <= pfc_pkg::BLANK_WORD;
            end
        end
        else if (do_erase || do_commit)
        begin
            for (int k = 0; k < pfc_pkg::ROW_WORDS; k++)
            begin
                latch_mem[k] <= pfc_pkg::BLANK_WORD; // see R26
            end
        end
        else if (do_latch)
        begin
            latch_mem[s_reg.addr[pfc_pkg::LAT_W-1:0]] <= s_reg.data;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign hreadyout_o = !(s_reg.ph_valid && !s_reg.ph_write);
    assign hresp_o     = 1'b0;
    assign hrdata_o    = s_reg.hrdata;
    assign ind_data_o  = s_reg.ind_data;
    assign ind_valid_o = s_reg.ind_valid;
    // Fetch halts for the whole timed operation or a one-cycle read
    assign cpu_stall_o = (s_reg.st == pfc_pkg::PFC_BUSY) ||
        (s_reg.st == pfc_pkg::PFC_READ) || ind_load_i; // see R20
    assign flash_done_irq_o = s_reg.done && s_reg.ie; // see R27

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_read_clears: assert property (@(posedge clk_i) disable iff (rst_i)
        s_reg.st == pfc_pkg::PFC_READ |=> !s_reg.rd &&
        s_reg.st == pfc_pkg::PFC_IDLE) // see R11
        else $error("Read trigger not cleared");
    a_read_data: assert property (@(posedge clk_i) disable iff (rst_i)
        s_reg.st == pfc_pkg::PFC_READ |=> s_reg.data == $past(rd_word))
        else $error("Read word not in data pair"); // see R10
    a_no_wr_locked: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(s_reg.wr) |-> $past(s_reg.unlock) == 2'd2 &&
        $past(s_reg.write_enable_gate)) // see R18
        else $error("Operation started without unlock");
    a_unlock_break: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_en && s_reg.ph_addr != pfc_pkg::OFS_UNLOCK |=>
        s_reg.unlock == 2'd0) // see R29
        else $error("Unlock chain not broken");
    a_prot_refused: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_en && s_reg.ph_addr == pfc_pkg::OFS_CONTROL &&
        wd8[pfc_pkg::CTL_WR] && s_reg.unlock == 2'd2 && s_reg.write_enable_gate &&
        target_prot && !(s_reg.latch_only_select && !s_reg.free) &&
        s_reg.st == pfc_pkg::PFC_IDLE |=> s_reg.err && !s_reg.wr)
        else $error("Protected write not refused"); // see R13
    a_stall_busy: assert property (@(posedge clk_i) disable iff (rst_i)
        s_reg.wr |-> cpu_stall_o) // see R20
        else $error("No stall while busy");
    a_done_end: assert property (@(posedge clk_i) disable iff (rst_i)
        s_reg.st == pfc_pkg::PFC_BUSY && s_reg.tmr == 17'd0 |=>
        s_reg.done && !s_reg.wr) // see R27
        else $error("Completion not flagged");
    a_ind_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        ind_load_i && !ind_store_i && !ind_pointer_i[15] |=>
        ind_valid_o && ind_data_o == 8'h00) // see R6
        else $error("Indirect non-flash read not zero");
    a_irq_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        flash_done_irq_o |-> s_reg.done && s_reg.ie) // see R27
        else $error("Interrupt without flag and enable");
    c_erase: cover property (@(posedge clk_i) disable iff (rst_i)
        do_erase);
    c_commit: cover property (@(posedge clk_i) disable iff (rst_i)
        do_commit);
    c_latch: cover property (@(posedge clk_i) disable iff (rst_i)
        do_latch);
    c_bulk: cover property (@(posedge clk_i) disable iff (rst_i)
        do_bulk);

endmodule

// >>> pfc_pkg.sv
package pfc_pkg;

    // ------------------------------------------------------------
    // Array geometry
    // ------------------------------------------------------------
    localparam int ADDR_W     = 15;
    localparam int WORD_W     = 14;
    localparam int ROW_WORDS  = 32;
    localparam int LAT_W      = 5;
    localparam int PFM_WORDS  = 16384;
    localparam int CFG_WORDS  = 12;
    localparam logic [13:0] BLANK_WORD = 14'h3fff;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_ADDR_LOW  = 8'h00;
    localparam logic [7:0] OFS_ADDR_HIGH = 8'h04;
    localparam logic [7:0] OFS_DATA_LOW  = 8'h08;
    localparam logic [7:0] OFS_DATA_HIGH = 8'h0c;
    localparam logic [7:0] OFS_CONTROL   = 8'h10;
    localparam logic [7:0] OFS_UNLOCK    = 8'h14;
    localparam logic [7:0] OFS_STATUS    = 8'h18;

    // Control register bit positions
    localparam int CTL_RD   = 0;
    localparam int CTL_WR   = 1;
    localparam int CTL_WRITE_ENABLE_GATE = 2;
    localparam int CTL_ERR  = 3;
    localparam int CTL_FREE = 4;
    localparam int CTL_LATCH_ONLY_SELECT = 5;
    localparam int CTL_SEL  = 6;
    // Status register bit positions
    localparam int STS_DONE = 0;
    localparam int STS_IE   = 1;

    localparam logic [7:0] UNLOCK_CODE_1 = 8'h55;
    localparam logic [7:0] UNLOCK_CODE_2 = 8'haa;

    // ------------------------------------------------------------
    // Configuration space map
    // ------------------------------------------------------------
    localparam logic [14:0] CS_UID_LAST  = 15'h0003;
    localparam logic [14:0] CS_REV_ID    = 15'h0005;
    localparam logic [14:0] CS_DEV_ID    = 15'h0006;
    localparam logic [14:0] CS_CFG_FIRST = 15'h0007;
    localparam logic [14:0] CS_CFG_LAST  = 15'h000b;
    localparam logic [14:0] CS_INFO_LO   = 15'h0100;
    localparam logic [14:0] CS_INFO_HI   = 15'h02ff;
    localparam logic [14:0] IND_FLASH_SEL = 15'h4000;
    localparam int          PROT_WORD    = 11;
    localparam int          CP_N_BIT     = 0;
    localparam int          WP_N_BIT     = 1;
    localparam logic [14:0] WP_LIMIT     = 15'h0800;
    localparam logic [13:0] REV_ID_VAL   = 14'h0a5a; // arbitrary value
    localparam logic [13:0] DEV_ID_VAL   = 14'h1234; // arbitrary value
    localparam logic [13:0] INFO_FILL    = 14'h3fff;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ     = 40;
    localparam int OP_TIME_US  = 2500;
    localparam int OP_CYCLES_DFLT = OP_TIME_US * CLK_MHZ;

    typedef enum logic [1:0] {
        PFC_IDLE  = 2'b00,
        PFC_READ  = 2'b01,
        PFC_BUSY  = 2'b11,
        PFC_SWEEP = 2'b10
    } pfc_state_t;

endpackage

// >>> pfc_pgm_model.sv
`timescale 1ns/1ps

module pfc_pgm_model (
    input  wire logic clk_i,
    input  wire logic go_i,
    input  wire logic cfg_go_i,
    output logic      bulk_erase_o,
    output logic      cfg_erase_o
);
    // Only the programmer side can issue a bulk erase
    always_ff @(posedge clk_i) bulk_erase_o <= go_i;
    always_ff @(posedge clk_i) cfg_erase_o <= cfg_go_i;
endmodule

// >>> tb_program_flash_self_write_control.sv
`timescale 1ns/1ps

module tb_program_flash_self_write_control;
    logic        clk_i = 0, rst_i = 1, hsel = 0, hwrite = 0;
    logic        ind_load = 0, ind_store = 0, go = 0, cfg_go = 0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
    logic        hready, ind_valid, stall, irq, pab, blk, cfg;
    logic [15:0] ptr = 16'h0;
    logic [7:0]  ind_data;
    logic [13:0] w;
    int          n_fail = 0;
    int          cmp_count = 0;

    initial forever #12.5 clk_i = ~clk_i;

    pfc_pgm_model pfc_pgm_model_i (.clk_i(clk_i), .go_i(go),
        .cfg_go_i(cfg_go),
        .bulk_erase_o(blk), .cfg_erase_o(cfg));

    pfc_flash_ctrl #(.OP_CYCLES(8)) pfc_flash_ctrl_i (.clk_i(clk_i),
        .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
        .hready_i(hready), .hreadyout_o(hready), .hresp_o(),
        .hrdata_o(hrdata), .ind_load_i(ind_load), .ind_store_i(ind_store),
        .ind_pointer_i(ptr), .ind_data_o(ind_data), .ind_valid_o(ind_valid),
        .cpu_stall_o(stall), .flash_done_irq_o(irq),
        .pgm_bulk_erase_i(blk), .pgm_cfg_erase_i(cfg),
        .pgm_access_block_o(pab));

    // ------------------------------------------------------------
    // Bus and check helpers
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, s);
        cmp_count++;
        if (s !== e)
        begin
            n_fail++;
            $display("unexpected %s exp %h seen %h", nm, e, s);
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        @(posedge clk_i);
        while (hready !== 1'b1) @(posedge clk_i);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk_i);
        while (hready !== 1'b1) @(posedge clk_i);
        r = hrdata;
    endtask

    task automatic unlock(input logic [31:0] c);
        bus(1, 8'h10, c & ~32'h2);
        bus(1, 8'h14, 32'h55);
        bus(1, 8'h14, 32'haa);
        bus(1, 8'h10, c);
    endtask

    task automatic waitop;
        @(posedge clk_i);
        for (int i = 0; i < 100 && stall; i++) @(posedge clk_i);
        chk("stall", 0, stall);
    endtask

    task automatic rdw(input logic [14:0] a);
        bus(1, 8'h00, {24'h0, a[7:0]});
        bus(1, 8'h04, {25'h0, a[14:8]});
        bus(1, 8'h10, 32'h1);
        bus(0, 8'h10, 32'h0);
        chk("rd bit", 0, r[0]);
        bus(0, 8'h08, 32'h0);
        w[7:0] = r[7:0];
        bus(0, 8'h0c, 32'h0);
        w[13:8] = r[5:0];
    endtask

    task close_out;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_prog;
        bus(1, 8'h08, 32'hbc);
        bus(1, 8'h0c, 32'h1a);
        bus(1, 8'h00, 32'h40);
        bus(1, 8'h04, 32'h08);
        unlock(32'h26);
        unlock(32'h06);
        waitop;
        bus(0, 8'h18, 32'h0);
        chk("done", 1, r[0]);
        chk("irq", 0, irq);
        bus(1, 8'h18, 32'h2);
        bus(0, 8'h18, 32'h0);
        chk("irq on", 1, irq);
        bus(0, 8'h10, 32'h0);
        chk("wr bit", 0, r[1]);
        rdw(15'h0840);
        chk("word", 14'h1abc, w);
        rdw(15'h0842);
        chk("blank", 14'h3fff, w);
        $display("program test done");
    endtask

    task automatic t_unlock;
        bus(1, 8'h18, 32'h1);
        bus(1, 8'h10, 32'h14);
        bus(1, 8'h14, 32'h55);
        bus(1, 8'h00, 32'h40);
        bus(1, 8'h14, 32'haa);
        bus(1, 8'h10, 32'h16);
        rdw(15'h0840);
        chk("kept", 14'h1abc, w);
        unlock(32'h16);
        waitop;
        rdw(15'h0840);
        chk("erased", 14'h3fff, w);
        $display("unlock test done");
    endtask

    task automatic t_ind;
        ptr <= 16'h8842;
        ind_store <= 1'b1;
        @(posedge clk_i);
        ind_store <= 1'b0;
        ptr <= 16'h8840;
        ind_load <= 1'b1;
        @(posedge clk_i);
        chk("ind stall", 1, stall);
        ind_load <= 1'b0;
        @(posedge clk_i);
        chk("ind valid", 1, ind_valid);
        ptr <= 16'h0840;
        ind_load <= 1'b1;
        @(posedge clk_i);
        ind_load <= 1'b0;
        @(posedge clk_i);
        chk("ind zero", 8'h0, ind_data);
        rdw(15'h0842);
        chk("no store", 14'h3fff, w);
        $display("indirect test done");
    endtask

    task automatic t_prot;
        bus(1, 8'h00, 32'h0b);
        bus(1, 8'h04, 32'h00);
        bus(1, 8'h08, 32'hfc);
        bus(1, 8'h0c, 32'h3f);
        unlock(32'h66);
        unlock(32'h46);
        waitop;
        chk("cp pin", 1, pab);
        unlock(32'h16);
        bus(0, 8'h10, 32'h0);
        chk("err", 1, r[3]);
        chk("wr off", 0, r[1]);
        cfg_go <= 1'b1;
        repeat (4) @(posedge clk_i);
        cfg_go <= 1'b0;
        repeat (16500) @(posedge clk_i);
        chk("cp cleared", 0, pab);
        $display("protect test done");
    endtask

    initial
    begin
        fork
        begin
            #1000000;
            n_fail++;
            close_out();
        end
        join_none
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        go <= 1'b1;
        repeat (4) @(posedge clk_i);
        go <= 1'b0;
        repeat (16500) @(posedge clk_i);
        chk("blocked", 0, pab);
        t_prog();
        t_unlock();
        t_ind();
        t_prot();
        close_out();
    end

    always @(posedge clk_i)
        if (ind_valid === 1'b1 && ptr === 16'h8840)
            chk("ind byte", 8'hff, ind_data);
endmodule
